// ### tcc_adc_model.sv
/*
 Converter model: answers each start with nonzero lat_i with one done pulse and a code; lat_i of zero gets no answer.
 Assumes start and channel select come registered from the conversion block.
*/
`timescale 1ns/1ps
module tcc_adc_model
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic remote_i,
   input wire logic [3:0] lat_i,
   input wire logic [RESULT_W-1:0] code_l_i,
   input wire logic [RESULT_W-1:0] code_r_i,
   output tcc_adc_rsp_t rsp_o
);
   logic [3:0] cnt;
   logic rem;
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt <= 4'h0;
         rem <= 1'b0;
         rsp_o <= '0;
      end
      else
      begin
         rsp_o.done <= 1'b0;
         // Code toggles between answers so a stale sample never matches
         rsp_o.code <= ~rsp_o.code;
         if (start_i)
         begin
            cnt <= lat_i;
            rem <= remote_i;
         end
         else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
         if (!start_i && cnt == 4'h1)
            rsp_o <= '{done: 1'b1, code: rem ? code_r_i : code_l_i};
      end
   end
endmodule : tcc_adc_model

// ### tcc_conversion_control.sv
/*
 Conversion sequencing, run filtering and remote calibration of a temperature monitor.
 Assumes a bus engine presenting pointer writes and reads as one-cycle strobes, an
 external converter answering each start with a done pulse, and an external limit
 comparator judging the stored results in the same cycle as result_valid_o.
*/
`timescale 1ns/1ps
module tcc_conversion_control
   import tcc_pkg::*;
#(
   parameter int unsigned SLOWEST_PERIOD = SLOWEST_PERIOD_CYC
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire tcc_reg_wr_t reg_wr_i,
   input wire logic rd_en_i,
   input wire logic [7:0] rd_ptr_i,
   input wire logic halt_conversion_bit_i,
   input wire logic [7:0] rate_code_i,
   input wire logic [RESULT_W-1:0] remote_offset_i,
   input wire tcc_adc_rsp_t adc_rsp_i,
   input wire tcc_limit_t local_limit_i,
   input wire tcc_limit_t remote_limit_i,
   output logic [7:0] rdata_o,
   output logic adc_start_o,
   output logic adc_remote_o,
   output logic busy_o,
   output logic [RESULT_W-1:0] local_result_o,
   output logic [RESULT_W-1:0] remote_result_o,
   output logic result_valid_o,
   output logic limit_event_o
);

   tcc_state_t state_ff;
   tcc_state_t nxt_state;

   logic [1:0] channel_select_ff;
   logic [3:0] repeat_count_ff;
   logic [7:0] ideality_trim_ff;
   logic [7:0] rdata_ff;
   logic single_pending_ff;
   logic single_run_ff;
   logic adc_start_ff;
   logic adc_remote_ff;
   logic busy_ff;
   logic result_valid_ff;
   logic limit_event_ff;
   logic [RESULT_W-1:0] local_result_ff;
   logic [RESULT_W-1:0] remote_result_ff;
   logic [31:0] period_cnt_ff;

   // Register decode
   wire logic wr_single = reg_wr_i.en && (reg_wr_i.ptr == PTR_SINGLE_SHOT);
   wire logic wr_channel = reg_wr_i.en && (reg_wr_i.ptr == PTR_CHANNEL_SELECT);
   wire logic wr_repeat = reg_wr_i.en && (reg_wr_i.ptr == PTR_REPEAT_COUNT);
   wire logic wr_trim = reg_wr_i.en && (reg_wr_i.ptr == PTR_IDEALITY_TRIM);
   wire logic local_on = channel_select_ff[LOCAL_CHANNEL_ON_POS];
   wire logic remote_on = channel_select_ff[REMOTE_CHANNEL_ON_POS];

   // Read mux; the trigger pointer stores nothing and reads as zero
   wire logic [7:0] nxt_rdata =
      (rd_ptr_i == PTR_CHANNEL_SELECT) ? {6'h00, channel_select_ff} :
      (rd_ptr_i == PTR_REPEAT_COUNT) ? {4'h0, repeat_count_ff} :
      (rd_ptr_i == PTR_IDEALITY_TRIM) ? ideality_trim_ff :
      (rd_ptr_i == PTR_MAKER_ID) ? MAKER_ID_VALUE :
      READ_NONE;

   // Thermometer code to run length; odd codes fall back to the top set bit
   wire logic [2:0] need_count = repeat_count_ff[3] ? 3'h4 :
                                 repeat_count_ff[2] ? 3'h3 :
                                 repeat_count_ff[1] ? 3'h2 : 3'h1;

   // Sequence period: halves per rate step, capped at the fastest code
   wire logic [7:0] rate_sel = (rate_code_i > RATE_CODE_MAX) ? RATE_CODE_MAX : rate_code_i;
   wire logic [31:0] period_cyc = 32'(SLOWEST_PERIOD) >> rate_sel[3:0];
   wire logic period_due = (period_cnt_ff >= 32'(period_cyc - 32'h1));

   // Remote correction: T * (2088 + N) / 2088, then the offset in result format
   wire logic signed [RESULT_W-1:0] raw_signed = $signed(adc_rsp_i.code);
   wire logic signed [13:0] trim_scale = IDEALITY_BASE + 14'($signed(ideality_trim_ff));
   wire logic signed [26:0] scaled_prod = 27'(raw_signed) * 27'(trim_scale);
   wire logic signed [26:0] scaled_div = scaled_prod / 27'(IDEALITY_BASE);
   // Wraps rather than saturates; range clamping belongs to the comparator side
   wire logic [RESULT_W-1:0] remote_corrected =
      RESULT_W'(scaled_div[RESULT_W-1:0] + remote_offset_i);

   // A sequence starts from either idle state
   wire logic start_from_halt = !halt_conversion_bit_i || single_pending_ff;
   wire logic start_from_wait = period_due || (halt_conversion_bit_i && single_pending_ff);
   wire logic seq_start =
      ((state_ff == ST_HALTED) && start_from_halt) ||
      ((state_ff == ST_WAIT) && start_from_wait);
   wire logic seq_is_single = halt_conversion_bit_i && single_pending_ff;
   wire logic local_done = (state_ff == ST_LOCAL_CONV) && adc_rsp_i.done;
   wire logic remote_done = (state_ff == ST_REMOTE_CONV) && adc_rsp_i.done;
   wire logic local_sample = (state_ff == ST_LOCAL_CMP);
   wire logic remote_sample = (state_ff == ST_REMOTE_CMP);
   // Where the sequence goes after its last channel
   wire logic end_to_halt = halt_conversion_bit_i || single_run_ff;
   wire logic first_is_remote = !local_on && remote_on;
   wire logic issue_local = seq_start && local_on;
   wire logic issue_remote = (seq_start && first_is_remote) ||
                             (local_sample && remote_on);
   wire logic local_event;
   wire logic remote_event;

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_HALTED, ST_WAIT:
         begin
            if (seq_start)
            begin
               // One channel only: half the busy time of a full sequence
               if (local_on)
                  nxt_state = ST_LOCAL_CONV;
               else if (remote_on)
                  nxt_state = ST_REMOTE_CONV;
               else if (halt_conversion_bit_i)
                  nxt_state = ST_HALTED;
               else
                  nxt_state = ST_WAIT;
            end
            else if ((state_ff == ST_WAIT) && halt_conversion_bit_i)
               nxt_state = ST_HALTED;
         end
         ST_LOCAL_CONV:
         begin
            if (adc_rsp_i.done)
               nxt_state = ST_LOCAL_CMP;
         end
         ST_LOCAL_CMP:
         begin
            if (remote_on)
               nxt_state = ST_REMOTE_CONV;
            else
               nxt_state = end_to_halt ? ST_HALTED : ST_WAIT;
         end
         ST_REMOTE_CONV:
         begin
            if (adc_rsp_i.done)
               nxt_state = ST_REMOTE_CMP;
         end
         ST_REMOTE_CMP:
         begin
            nxt_state = end_to_halt ? ST_HALTED : ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         state_ff <= ST_HALTED;
      else
         state_ff <= nxt_state;
   end

   // Host registers
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         channel_select_ff <= CHANNEL_SELECT_RST;
         repeat_count_ff <= REPEAT_COUNT_RST;
         ideality_trim_ff <= IDEALITY_TRIM_RST;
      end
      else
      begin
         if (wr_channel)
            channel_select_ff <= reg_wr_i.data[1:0];
         if (wr_repeat)
            repeat_count_ff <= reg_wr_i.data[3:0];
         if (wr_trim)
            ideality_trim_ff <= reg_wr_i.data;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_ff <= READ_NONE;
      else if (rd_en_i)
         rdata_ff <= nxt_rdata;
   end

   // Trigger: only the write event is kept, its data byte is dropped. A trigger with halt_conversion_bit_i
   // set during a running sequence is held and served once that sequence ends; with it clear the trigger is dropped.
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         single_pending_ff <= 1'b0;
      else if (wr_single && halt_conversion_bit_i)
         single_pending_ff <= 1'b1;
      else if (seq_start || !halt_conversion_bit_i)
         single_pending_ff <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         single_run_ff <= 1'b0;
      else if (seq_start)
         single_run_ff <= seq_is_single;
   end

   // Period timer restarts with each sequence
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         period_cnt_ff <= 32'h0;
      else if (seq_start || (state_ff == ST_HALTED))
         period_cnt_ff <= 32'h0;
      else if (!period_due)
         period_cnt_ff <= period_cnt_ff + 32'h1;
   end

   // Converter handshake
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         adc_start_ff <= 1'b0;
         adc_remote_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         adc_start_ff <= issue_local || issue_remote;
         if (issue_remote)
            adc_remote_ff <= 1'b1;
         else if (issue_local)
            adc_remote_ff <= 1'b0;
         busy_ff <= (nxt_state == ST_LOCAL_CONV) || (nxt_state == ST_REMOTE_CONV);
      end
   end

   // Result store: local raw, remote calibrated
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         local_result_ff <= '0;
         remote_result_ff <= '0;
         result_valid_ff <= 1'b0;
      end
      else
      begin
         if (local_done)
            local_result_ff <= adc_rsp_i.code;
         if (remote_done)
            remote_result_ff <= remote_corrected;
         result_valid_ff <= local_done || remote_done;
      end
   end

   tcc_run_filter u_local_filter
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sample_i(local_sample),
      .flags_i(local_limit_i),
      .need_i(need_count),
      .event_o(local_event)
   );

   tcc_run_filter u_remote_filter
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sample_i(remote_sample),
      .flags_i(remote_limit_i),
      .need_i(need_count),
      .event_o(remote_event)
   );

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         limit_event_ff <= 1'b0;
      else
         limit_event_ff <= local_event || remote_event;
   end

   assign rdata_o = rdata_ff;
   assign adc_start_o = adc_start_ff;
   assign adc_remote_o = adc_remote_ff;
   assign busy_o = busy_ff;
   assign local_result_o = local_result_ff;
   assign remote_result_o = remote_result_ff;
   assign result_valid_o = result_valid_ff;
   assign limit_event_o = limit_event_ff;

endmodule : tcc_conversion_control

// ### tcc_pkg.sv
/*
 Constants, register map and carrier types of the temperature conversion control block.
 Assumes one 25 MHz clock and a register port driven by an external two-wire bus engine.
*/
package tcc_pkg;

   // Pointer addresses
   localparam logic [7:0] PTR_SINGLE_SHOT = 8'h0F;
   localparam logic [7:0] PTR_CHANNEL_SELECT = 8'h16;
   localparam logic [7:0] PTR_REPEAT_COUNT = 8'h22;
   localparam logic [7:0] PTR_IDEALITY_TRIM = 8'h23;
   localparam logic [7:0] PTR_MAKER_ID = 8'hFE;

   // Field positions and reset values
   localparam int LOCAL_CHANNEL_ON_POS = 0;
   localparam int REMOTE_CHANNEL_ON_POS = 1;
   localparam logic [1:0] CHANNEL_SELECT_RST = 2'h3;
   localparam logic [3:0] REPEAT_COUNT_RST = 4'h1;
   localparam logic [7:0] IDEALITY_TRIM_RST = 8'h00;
   localparam logic [7:0] READ_NONE = 8'h00;

   // Arbitrary neutral maker code
   localparam logic [7:0] MAKER_ID_VALUE = 8'hA5;

   // Ideality scaling base
   localparam logic signed [13:0] IDEALITY_BASE = 14'sh0828;

   // Rate timing: code 00h gives the slowest period, each step halves it
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned SLOWEST_PERIOD_S = 16;
   localparam int unsigned SLOWEST_PERIOD_CYC = SLOWEST_PERIOD_S * CLK_HZ;
   localparam logic [7:0] RATE_CODE_MAX = 8'h09;
   localparam int RESULT_W = 12;

   typedef struct packed
   {
      logic en;
      logic [7:0] ptr;
      logic [7:0] data;
   } tcc_reg_wr_t;

   typedef struct packed
   {
      logic high;
      logic low;
   } tcc_limit_t;

   typedef struct packed
   {
      logic done;
      logic [RESULT_W-1:0] code;
   } tcc_adc_rsp_t;

   typedef enum logic [2:0]
   {
      ST_HALTED,
      ST_WAIT,
      ST_LOCAL_CONV,
      ST_LOCAL_CMP,
      ST_REMOTE_CONV,
      ST_REMOTE_CMP
   } tcc_state_t;

endpackage : tcc_pkg

// ### tcc_props.sv
/*
 Port checks of the conversion control block.
 Assumes a bind to tcc_conversion_control; helper logic shadows host writes.
*/
`timescale 1ns/1ps
module tcc_props
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire tcc_reg_wr_t reg_wr_i,
   input wire logic rd_en_i,
   input wire logic [7:0] rd_ptr_i,
   input wire logic halt_conversion_bit_i,
   input wire logic [RESULT_W-1:0] remote_offset_i,
   input wire tcc_adc_rsp_t adc_rsp_i,
   input wire tcc_limit_t local_limit_i,
   input wire logic [7:0] rdata_o,
   input wire logic adc_start_o,
   input wire logic adc_remote_o,
   input wire logic busy_o,
   input wire logic [RESULT_W-1:0] local_result_o,
   input wire logic [RESULT_W-1:0] remote_result_o,
   input wire logic result_valid_o,
   input wire logic limit_event_o
);
   logic [1:0] ch_ff;
   logic [3:0] rep_ff;
   logic signed [7:0] trim_ff;
   logic [RESULT_W-1:0] rexp_ff;
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ch_ff <= CHANNEL_SELECT_RST;
         rep_ff <= REPEAT_COUNT_RST;
         trim_ff <= IDEALITY_TRIM_RST;
      end
      else if (reg_wr_i.en)
      begin
         if (reg_wr_i.ptr == PTR_CHANNEL_SELECT)
            ch_ff <= reg_wr_i.data[1:0];
         if (reg_wr_i.ptr == PTR_REPEAT_COUNT)
            rep_ff <= reg_wr_i.data[3:0];
         if (reg_wr_i.ptr == PTR_IDEALITY_TRIM)
            trim_ff <= reg_wr_i.data;
      end
   end
   // Corrected remote value, ready one cycle after the done pulse
   always_ff @(posedge clk_i)
      rexp_ff <= RESULT_W'(int'(signed'(adc_rsp_i.code)) * (2088 + int'(trim_ff)) / 2088
         + int'(signed'(remote_offset_i)));
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   a_maker_id_read: assert property (
      rd_en_i && rd_ptr_i == PTR_MAKER_ID |=> rdata_o == MAKER_ID_VALUE) else $error("bad id");
   a_trigger_reads_zero: assert property (
      rd_en_i && rd_ptr_i == PTR_SINGLE_SHOT |=> rdata_o == READ_NONE) else $error("bad 0F");
   a_chan_read_back: assert property (
      rd_en_i && !reg_wr_i.en && rd_ptr_i == PTR_CHANNEL_SELECT |=> rdata_o == {6'h00, ch_ff})
      else $error("bad channel read");
   a_count_read_back: assert property (
      rd_en_i && !reg_wr_i.en && rd_ptr_i == PTR_REPEAT_COUNT |=> rdata_o == {4'h0, rep_ff})
      else $error("bad count read");
   a_local_start_en: assert property (adc_start_o && !adc_remote_o |-> ch_ff[0])
      else $error("local start while off");
   a_remote_start_en: assert property (adc_start_o && adc_remote_o |-> ch_ff[1])
      else $error("remote start while off");
   a_local_raw: assert property (
      adc_rsp_i.done && busy_o && !adc_remote_o |=> local_result_o == $past(adc_rsp_i.code))
      else $error("local result altered");
   a_remote_corr: assert property (
      adc_rsp_i.done && busy_o && adc_remote_o |=> remote_result_o == rexp_ff)
      else $error("remote correction wrong");
   a_event_single: assert property (
      result_valid_o && rep_ff == 4'h1 ##1 !adc_remote_o && (local_limit_i.high
      || local_limit_i.low) |-> ##[1:3] limit_event_o) else $error("event missing");
   a_busy_at_start: assert property (adc_start_o |-> busy_o)
      else $error("start without busy");
   a_busy_ends: assert property (result_valid_o |-> !busy_o)
      else $error("busy after result");
   a_trigger_starts: assert property (
      halt_conversion_bit_i && reg_wr_i.en && reg_wr_i.ptr == PTR_SINGLE_SHOT && ch_ff != 2'h0
      && !busy_o |-> ##[1:4] adc_start_o) else $error("trigger ignored");
   c_remote_store: cover property (result_valid_o && adc_remote_o);
   c_event_rise: cover property ($rose(limit_event_o));
   c_trigger: cover property (reg_wr_i.en && reg_wr_i.ptr == PTR_SINGLE_SHOT ##2 adc_start_o);
endmodule : tcc_props

// ### tcc_run_filter.sv
/*
 Consecutive out-of-limit run filter for one channel.
 Assumes flags_i is valid in the cycle sample_i pulses.
*/
`timescale 1ns/1ps
module tcc_run_filter
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic sample_i,
   input wire tcc_limit_t flags_i,
   input wire logic [2:0] need_i,
   output logic event_o
);

   logic [2:0] high_run_ff;
   logic [2:0] low_run_ff;
   logic event_ff;
   wire logic [2:0] nxt_high_run;
   wire logic [2:0] nxt_low_run;

   // Saturate at four; an in-limit result restarts the run
   assign nxt_high_run = !flags_i.high ? 3'h0 :
                         (high_run_ff == 3'h4) ? 3'h4 : 3'(high_run_ff + 3'h1);
   assign nxt_low_run = !flags_i.low ? 3'h0 :
                        (low_run_ff == 3'h4) ? 3'h4 : 3'(low_run_ff + 3'h1);

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         high_run_ff <= 3'h0;
         low_run_ff <= 3'h0;
         event_ff <= 1'b0;
      end
      else if (sample_i)
      begin
         high_run_ff <= nxt_high_run;
         low_run_ff <= nxt_low_run;
         event_ff <= (nxt_high_run >= need_i) || (nxt_low_run >= need_i);
      end
   end

   assign event_o = event_ff;

endmodule : tcc_run_filter

// ### tcc_tb.sv
/*
 Self-checking bench of the conversion control block.
 Assumes the converter model and the checker files compiled before it.
*/
`timescale 1ns/1ps
module testbench
   import tcc_pkg::*;
;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   tcc_reg_wr_t reg_wr_i = '0;
   logic rd_en_i = 1'b0;
   logic [7:0] rd_ptr_i = 8'h00;
   logic halt_conversion_bit_i = 1'b1;
   logic [7:0] rate_code_i = 8'h08;
   logic [RESULT_W-1:0] remote_offset_i = '0;
   tcc_adc_rsp_t adc_rsp_i;
   tcc_limit_t local_limit_i = '0;
   tcc_limit_t remote_limit_i = '0;
   logic [7:0] rdata_o;
   logic adc_start_o, adc_remote_o, busy_o, result_valid_o, limit_event_o;
   logic [RESULT_W-1:0] local_result_o, remote_result_o, code_l, code_r;
   logic [3:0] lat = 4'h2;
   logic [1:0] ch = 2'h3;
   logic signed [7:0] trim = 8'sh00;
   logic [7:0] rd_q[$];
   logic [RESULT_W-1:0] res_q[$];
   logic rd_d = 1'b0;
   logic free_run = 1'b0;
   int err_count = 0;
   int compares = 0;
   int nres = 0;
   int nst = 0;
   int cyc = 0;
   int last_st = 0;
   int gap = 0;
   tcc_conversion_control #(.SLOWEST_PERIOD(2560)) i_tcc_conversion_control (.clk_i, .sys_rst_i,
      .reg_wr_i, .rd_en_i, .rd_ptr_i, .halt_conversion_bit_i, .rate_code_i, .remote_offset_i,
      .adc_rsp_i, .local_limit_i, .remote_limit_i, .rdata_o, .adc_start_o, .adc_remote_o, .busy_o,
      .local_result_o, .remote_result_o, .result_valid_o, .limit_event_o);
   tcc_adc_model i_tcc_adc_model (.clk_i, .sys_rst_i, .start_i(adc_start_o),
      .remote_i(adc_remote_o), .lat_i(lat), .code_l_i(code_l), .code_r_i(code_r), .rsp_o(adc_rsp_i));
   initial
      forever #20 clk_i = ~clk_i;
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [RESULT_W-1:0] rexp(input logic [RESULT_W-1:0] c);
      return RESULT_W'(int'(signed'(c)) * (2088 + int'(trim)) / 2088 + int'(signed'(remote_offset_i)));
   endfunction : rexp
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      reg_wr_i <= '{en: 1'b1, ptr: p, data: d};
      @(posedge clk_i);
      reg_wr_i.en <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      rd_q.push_back(e);
      rd_en_i <= 1'b1;
      rd_ptr_i <= p;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      @(posedge clk_i);
   endtask : rd
   // One trigger, then a quiet spell to catch any extra conversion
   task automatic shot(input tcc_limit_t f, input logic ev);
      int n0, s0, n, i;
      n0 = nres;
      s0 = nst;
      n = ch[0] + ch[1];
      code_l = RESULT_W'($urandom);
      code_r = RESULT_W'($urandom);
      if (ch[0]) res_q.push_back(code_l);
      if (ch[1]) res_q.push_back(rexp(code_r));
      local_limit_i <= f;
      remote_limit_i <= f;
      lat <= 4'($urandom_range(1, 6));
      wr(PTR_SINGLE_SHOT, 8'($urandom));
      for (i = 0; i < 300 && nres < n0 + n; i++)
         @(posedge clk_i);
      if (i == 300)
      begin
         err_count++;
         end_of_test();
      end
      repeat (20) @(posedge clk_i);
      check(16'(nst - s0), 16'(n));
      check(limit_event_o, ev);
   endtask : shot
   always @(posedge clk_i)
      rd_d <= rd_en_i;
   always @(negedge clk_i)
   begin
      if (rd_d)
         check(rdata_o, rd_q.pop_front());
      if (result_valid_o === 1'b1 && !free_run)
         check(adc_remote_o ? remote_result_o : local_result_o, res_q.pop_front());
      if (result_valid_o === 1'b1)
         nres++;
      if (adc_start_o === 1'b1)
      begin
         nst++;
         gap = cyc - last_st;
         last_st = cyc;
      end
      cyc++;
   end
   initial
   begin
      void'($urandom(72));
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(PTR_CHANNEL_SELECT, 8'h03);
      rd(PTR_REPEAT_COUNT, 8'h01);
      rd(PTR_IDEALITY_TRIM, 8'h00);
      rd(PTR_MAKER_ID, MAKER_ID_VALUE);
      rd(PTR_SINGLE_SHOT, READ_NONE);
      rd(8'h30, READ_NONE);
      for (int k = 0; k < 4; k++)
      begin
         wr(PTR_REPEAT_COUNT, 8'((1 << (k + 1)) - 1));
         rd(PTR_REPEAT_COUNT, 8'((1 << (k + 1)) - 1));
         shot('0, 1'b0);
         for (int j = 0; j <= k; j++)
            shot('{high: 1'b1, low: 1'b0}, j == k);
      end
      wr(PTR_REPEAT_COUNT, 8'h03);
      for (int j = 0; j < 4; j++)
         shot('{high: 1'b0, low: j != 1}, j == 3);
      for (int k = 0; k < 4; k++)
      begin
         ch = 2'(3 - k);
         trim = 8'($urandom);
         remote_offset_i <= RESULT_W'($urandom);
         wr(PTR_CHANNEL_SELECT, {6'h00, ch});
         wr(PTR_IDEALITY_TRIM, trim);
         rd(PTR_IDEALITY_TRIM, trim);
         shot('0, 1'b0);
      end
      // Free running, local only: start spacing follows the rate code
      ch = 2'h1;
      lat <= 4'h1;
      wr(PTR_CHANNEL_SELECT, 8'h01);
      free_run = 1'b1;
      // Second pass: codes above the fastest one act as the fastest
      for (int r = 0; r < 2; r++)
      begin
         nst = 0;
         if (r == 0)
            halt_conversion_bit_i <= 1'b0;
         else
            rate_code_i <= 8'($urandom_range(10, 255));
         for (int i = 0; i < 200 && nst < 3; i++)
            @(posedge clk_i);
         if (nst < 3)
         begin
            err_count++;
            end_of_test();
         end
         check(16'(gap), 16'(2560 >> (8 + r)));
      end
      halt_conversion_bit_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      nst = 0;
      repeat (40) @(posedge clk_i);
      check(16'(nst), 16'h0000);
      end_of_test();
   end
endmodule : testbench
bind tcc_conversion_control tcc_props i_tcc_props (.clk_i, .sys_rst_i, .reg_wr_i, .rd_en_i,
   .rd_ptr_i, .halt_conversion_bit_i, .remote_offset_i, .adc_rsp_i, .local_limit_i, .rdata_o,
   .adc_start_o, .adc_remote_o, .busy_o, .local_result_o, .remote_result_o, .result_valid_o,
   .limit_event_o);
